/* File: include/sock_pkg.sv */
package sock_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned LINGER_NS = 1000;
  // Least time, so round up
  localparam int unsigned LINGER_CYCLES = (LINGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_PROTO = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h01;
  localparam logic [7:0] OFS_FLAGS = 8'h02;
  localparam logic [7:0] OFS_STATE = 8'h03;
  localparam logic [7:0] OFS_MASK = 8'h2c;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PROTO_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] STATE_RST = 8'h00;

  // ==========================================================
  // Event flag positions
  localparam int unsigned EV_W = 5;
  localparam int unsigned EV_LINK_UP = 0;
  localparam int unsigned EV_PEER_FIN = 1;
  localparam int unsigned EV_DATA = 2;
  localparam int unsigned EV_EXPIRY = 3;
  localparam int unsigned EV_SEND_DONE = 4;

  // ==========================================================
  // Protocol select and commands
  localparam logic [3:0] PROTO_TCP = 4'h1;
  localparam logic [3:0] PROTO_UDP = 4'h2;
  localparam logic [3:0] PROTO_RAW = 4'h4;
  localparam logic [7:0] CMD_OPEN = 8'h01;
  localparam logic [7:0] CMD_LISTEN = 8'h02;
  localparam logic [7:0] CMD_CONNECT = 8'h04;
  localparam logic [7:0] CMD_PEER_FIN_FLAG = 8'h08;
  localparam logic [7:0] CMD_CLOSE = 8'h10;
  localparam logic [7:0] CMD_SEND = 8'h20;
  localparam logic [7:0] CMD_SEND_MAC = 8'h21;
  localparam logic [7:0] CMD_SEND_KEEP = 8'h22;

  // ==========================================================
  // Reported state codes
  localparam logic [7:0] SC_RELEASED = 8'h00;
  localparam logic [7:0] SC_TCP_OPENED = 8'h13;
  localparam logic [7:0] SC_AWAITING = 8'h14;
  localparam logic [7:0] SC_REQ_SENT = 8'h15;
  localparam logic [7:0] SC_REQ_RCVD = 8'h16;
  localparam logic [7:0] SC_SESSION_UP = 8'h17;
  localparam logic [7:0] SC_FINISH_PEND = 8'h18;
  localparam logic [7:0] SC_SHUTTING = 8'h1a;
  localparam logic [7:0] SC_LINGER = 8'h1b;
  localparam logic [7:0] SC_HALF_CLOSED = 8'h1c;
  localparam logic [7:0] SC_FINAL_WAIT = 8'h1d;
  localparam logic [7:0] SC_DATAGRAM = 8'h22;
  localparam logic [7:0] SC_RAW_FRAME = 8'h42;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic syn;
    logic synack;
    logic reply_ok;
    logic fin;
    logic finack;
    logic rst;
    logic data;
    logic send_done;
    logic address_resolution_expiry;
    logic retransmit_expiry;
  } peer_ev_t;

  typedef struct packed {
    logic send_syn;
    logic send_synack;
    logic send_fin;
    logic send_data;
    logic send_mac;
    logic send_keep;
    logic abort;
  } eng_req_t;

endpackage

/* File: verilog/sock_event_flags.sv */
`timescale 1ns/10ps
module sock_event_flags #(
  parameter int unsigned W = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Events and mask
  input wire logic [W-1:0] ev,
  input wire logic [W-1:0] mask,
  // Write-one-to-clear
  input wire logic clr_wr,
  input wire logic [W-1:0] clr_data,
  // Flags
  output logic [W-1:0] flags_ff
);

  logic [W-1:0] nxt_flags;

  // ==========================================================
  // Set wins over a clear in the same cycle
  always_comb begin
    nxt_flags = flags_ff;
    if (clr_wr) begin
      nxt_flags = nxt_flags & ~clr_data;
    end
    nxt_flags = nxt_flags | (ev & mask);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_ff <= sock_pkg::FLAGS_RST[W-1:0];
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ==========================================================
  // Checks
  chk_flag_set_masked: assert property (@(posedge clk) disable iff (!rstn)
    (ev & mask) != '0 |=> (flags_ff & $past(ev & mask)) == $past(ev & mask))
    else $error("masked event did not set its flag");

  chk_flag_clear_one: assert property (@(posedge clk) disable iff (!rstn)
    clr_wr |=> flags_ff == (($past(flags_ff) & ~$past(clr_data)) | $past(ev & mask)))
    else $error("write-one-to-clear misbehaved");

  chk_flag_no_unmasked: assert property (@(posedge clk) disable iff (!rstn)
    !clr_wr && (ev & mask) == '0 |=> $stable(flags_ff))
    else $error("flag changed with no cause");

endmodule // sock_event_flags

/* File: verilog/sock_state_ctrl.sv */
`timescale 1ns/10ps
// Behaviour
// - Masked socket event sets its flag bit
// - Writing one clears a flag, zero keeps
// - Bit 4 set when send finishes
// - Bit 3 set on either expiry
// - Bit 2 set on each data arrival
// - Bit 1 set on peer FIN
// - Bit 0 set once on reaching session
// - State moves only on commands, segments, expiries or linger timeout
// - Close, disconnect or timeout release socket
// - Open with TCP select gives 0x13
// - Awaiting client: accept or expire to released
// - Session state 0x17 after accept or connect
// - Peer FIN in session 0x17 gives half-closed 0x1C
// - Open with UDP select gives 0x22
// - Raw frame state only on socket zero
// - Request sent 0x15 until reply or expiry
// - Request received 0x16 until reply succeeds
// - Closing states end on completion or timeout
// - Final reply wait 0x1D ends released
// - Peer reset releases the socket in states 0x14 to 0x1D only
module sock_state_ctrl #(
  parameter int unsigned SOCKET_INDEX = 0,
  parameter int unsigned LINGER = sock_pkg::LINGER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire sock_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Peer segments and engine results
  input wire sock_pkg::peer_ev_t peer_ev,
  // Engine requests
  output sock_pkg::eng_req_t eng_req,
  // Status
  output logic [7:0] socket_state,
  output logic [7:0] socket_event_flags
);

  typedef enum {
    ST_RELEASED, ST_TCP_OPENED, ST_AWAITING, ST_REQ_SENT, ST_REQ_RCVD,
    ST_SESSION_UP, ST_FINISH_PEND, ST_SHUTTING, ST_LINGER, ST_HALF_CLOSED,
    ST_FINAL_WAIT, ST_DATAGRAM, ST_RAW_FRAME
  } sock_st_t;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] state_code(input sock_st_t s);
    case (s)
      ST_RELEASED: state_code = sock_pkg::SC_RELEASED;
      ST_TCP_OPENED: state_code = sock_pkg::SC_TCP_OPENED;
      ST_AWAITING: state_code = sock_pkg::SC_AWAITING;
      ST_REQ_SENT: state_code = sock_pkg::SC_REQ_SENT;
      ST_REQ_RCVD: state_code = sock_pkg::SC_REQ_RCVD;
      ST_SESSION_UP: state_code = sock_pkg::SC_SESSION_UP;
      ST_FINISH_PEND: state_code = sock_pkg::SC_FINISH_PEND;
      ST_SHUTTING: state_code = sock_pkg::SC_SHUTTING;
      ST_LINGER: state_code = sock_pkg::SC_LINGER;
      ST_HALF_CLOSED: state_code = sock_pkg::SC_HALF_CLOSED;
      ST_FINAL_WAIT: state_code = sock_pkg::SC_FINAL_WAIT;
      ST_DATAGRAM: state_code = sock_pkg::SC_DATAGRAM;
      ST_RAW_FRAME: state_code = sock_pkg::SC_RAW_FRAME;
      default: state_code = sock_pkg::SC_RELEASED;
    endcase
  endfunction

  // States that carry a live or pending TCP connection
  function automatic logic in_tcp_link(input sock_st_t s);
    in_tcp_link = (s != ST_RELEASED) && (s != ST_TCP_OPENED) &&
                  (s != ST_DATAGRAM) && (s != ST_RAW_FRAME);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // Registers
  sock_st_t st_ff;
  sock_st_t nxt_st;
  logic [7:0] state_ff;
  logic [7:0] proto_ff;
  logic [7:0] mask_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  sock_pkg::eng_req_t req_ff;
  sock_pkg::eng_req_t nxt_req;
  logic [15:0] linger_ff;
  logic [sock_pkg::EV_W-1:0] ev_vec;
  logic [sock_pkg::EV_W-1:0] flags_ff;
  logic cmd_wr;
  logic [7:0] cmd;
  logic any_expiry;
  logic linger_done;
  logic raw_allowed;

  assign cmd_wr = reg_req.wr && hit(reg_req.addr, sock_pkg::OFS_CMD);
  assign cmd = reg_req.wdata;
  assign any_expiry = peer_ev.address_resolution_expiry || peer_ev.retransmit_expiry;
  assign linger_done = (st_ff == ST_LINGER) && (linger_ff == 16'(LINGER - 1));
  // Raw frames only make sense on the first socket
  assign raw_allowed = (SOCKET_INDEX == 0);

  // ==========================================================
  // Socket state machine
  always_comb begin
    nxt_st = st_ff;
    nxt_req = '0;
    if (cmd_wr && cmd == sock_pkg::CMD_CLOSE) begin
      nxt_st = ST_RELEASED;
    end else if (peer_ev.rst && in_tcp_link(st_ff)) begin
      nxt_st = ST_RELEASED;
    end else if (peer_ev.retransmit_expiry && in_tcp_link(st_ff)) begin
      nxt_st = ST_RELEASED;
    end else if (peer_ev.address_resolution_expiry && st_ff == ST_REQ_SENT) begin
      nxt_st = ST_RELEASED;
    end else begin
      case (st_ff)
        ST_RELEASED: begin
          if (cmd_wr && cmd == sock_pkg::CMD_OPEN) begin
            if (proto_ff[3:0] == sock_pkg::PROTO_TCP) begin
              nxt_st = ST_TCP_OPENED;
            end else if (proto_ff[3:0] == sock_pkg::PROTO_UDP) begin
              nxt_st = ST_DATAGRAM;
            end else if (proto_ff[3:0] == sock_pkg::PROTO_RAW && raw_allowed) begin
              nxt_st = ST_RAW_FRAME;
            end
          end
        end
        ST_TCP_OPENED: begin
          // Listen and connect are honoured only here
          if (cmd_wr && cmd == sock_pkg::CMD_LISTEN) begin
            nxt_st = ST_AWAITING;
          end else if (cmd_wr && cmd == sock_pkg::CMD_CONNECT) begin
            nxt_st = ST_REQ_SENT;
            nxt_req.send_syn = 1'b1;
          end else if (cmd_wr && cmd == sock_pkg::CMD_PEER_FIN_FLAG) begin
            nxt_st = ST_RELEASED;
          end
        end
        ST_AWAITING: begin
          if (peer_ev.syn) begin
            nxt_st = ST_REQ_RCVD;
            nxt_req.send_synack = 1'b1;
          end else if (cmd_wr && cmd == sock_pkg::CMD_PEER_FIN_FLAG) begin
            nxt_st = ST_RELEASED;
          end
        end
        ST_REQ_SENT: begin
          if (peer_ev.synack) begin
            nxt_st = ST_SESSION_UP;
          end else if (cmd_wr && cmd == sock_pkg::CMD_PEER_FIN_FLAG) begin
            nxt_st = ST_RELEASED;
          end
        end
        ST_REQ_RCVD: begin
          if (peer_ev.reply_ok) begin
            nxt_st = ST_SESSION_UP;
          end else if (cmd_wr && cmd == sock_pkg::CMD_PEER_FIN_FLAG) begin
            nxt_st = ST_RELEASED;
          end
        end
        ST_SESSION_UP, ST_HALF_CLOSED: begin
          if (cmd_wr && cmd == sock_pkg::CMD_PEER_FIN_FLAG) begin
            nxt_st = (st_ff == ST_SESSION_UP) ? ST_FINISH_PEND : ST_FINAL_WAIT;
            nxt_req.send_fin = 1'b1;
          end else if (peer_ev.fin && st_ff == ST_SESSION_UP) begin
            nxt_st = ST_HALF_CLOSED;
          end else if (cmd_wr) begin
            nxt_req.send_data = (cmd == sock_pkg::CMD_SEND);
            nxt_req.send_keep = (cmd == sock_pkg::CMD_SEND_KEEP);
          end
        end
        ST_FINISH_PEND: begin
          if (peer_ev.finack) begin
            nxt_st = ST_RELEASED;
          end else if (peer_ev.fin) begin
            nxt_st = ST_SHUTTING;
          end
        end
        ST_SHUTTING: begin
          if (peer_ev.finack) begin
            nxt_st = ST_LINGER;
          end
        end
        ST_LINGER: begin
          if (linger_done) begin
            nxt_st = ST_RELEASED;
          end
        end
        ST_FINAL_WAIT: begin
          if (peer_ev.finack) begin
            nxt_st = ST_RELEASED;
          end
        end
        ST_DATAGRAM, ST_RAW_FRAME: begin
          if (cmd_wr && cmd == sock_pkg::CMD_PEER_FIN_FLAG) begin
            nxt_st = ST_RELEASED;
          end else if (cmd_wr) begin
            nxt_req.send_data = (cmd == sock_pkg::CMD_SEND);
            nxt_req.send_mac = (cmd == sock_pkg::CMD_SEND_MAC) && (st_ff == ST_DATAGRAM);
          end
        end
        default: nxt_st = ST_RELEASED;
      endcase
    end
    nxt_req.abort = (nxt_st == ST_RELEASED) && (st_ff != ST_RELEASED);
  end

  // Only commands, segments, expiries and the linger timer reach nxt_st
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= ST_RELEASED;
      state_ff <= sock_pkg::STATE_RST;
    end else begin
      st_ff <= nxt_st;
      state_ff <= state_code(nxt_st);
    end
  end

  // ==========================================================
  // Linger timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      linger_ff <= '0;
    end else if (st_ff == ST_LINGER) begin
      linger_ff <= linger_ff + 16'h0001;
    end else begin
      linger_ff <= '0;
    end
  end

  // ==========================================================
  // Engine requests, one-cycle pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_ff <= '0;
    end else begin
      req_ff <= nxt_req;
    end
  end

  // ==========================================================
  // Host-written registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      proto_ff <= sock_pkg::PROTO_RST;
      mask_ff <= sock_pkg::MASK_RST;
    end else if (reg_req.wr) begin
      if (hit(reg_req.addr, sock_pkg::OFS_PROTO)) begin
        proto_ff <= reg_req.wdata;
      end
      if (hit(reg_req.addr, sock_pkg::OFS_MASK)) begin
        mask_ff <= reg_req.wdata;
      end
    end
  end

  // ==========================================================
  // Event flags
  always_comb begin
    ev_vec = '0;
    ev_vec[sock_pkg::EV_SEND_DONE] = peer_ev.send_done;
    ev_vec[sock_pkg::EV_EXPIRY] = any_expiry;
    ev_vec[sock_pkg::EV_DATA] = peer_ev.data;
    ev_vec[sock_pkg::EV_PEER_FIN] = peer_ev.fin || peer_ev.finack;
    // Entry edge only, so a long session flags once
    ev_vec[sock_pkg::EV_LINK_UP] = (nxt_st == ST_SESSION_UP) && (st_ff != ST_SESSION_UP);
  end

  sock_event_flags #(
    .W(sock_pkg::EV_W)
  ) u_flags (
    .clk(clk),
    .rstn(rstn),
    .ev(ev_vec),
    .mask(mask_ff[sock_pkg::EV_W-1:0]),
    .clr_wr(reg_req.wr && hit(reg_req.addr, sock_pkg::OFS_FLAGS)),
    .clr_data(reg_req.wdata[sock_pkg::EV_W-1:0]),
    .flags_ff(flags_ff)
  );

  // ==========================================================
  // Read data
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_req.addr)
      sock_pkg::OFS_PROTO: nxt_rdata = proto_ff;
      sock_pkg::OFS_FLAGS: nxt_rdata = {3'h0, flags_ff};
      sock_pkg::OFS_STATE: nxt_rdata = state_ff;
      sock_pkg::OFS_MASK: nxt_rdata = mask_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else if (reg_req.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign eng_req = req_ff;
  assign socket_state = state_ff;
  assign socket_event_flags = {3'h0, flags_ff};

  // ==========================================================
  // Checks
  chk_send_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    peer_ev.send_done && mask_ff[4] |=> socket_event_flags[4])
    else $error("send completion flag missing");

  chk_expiry_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    any_expiry && mask_ff[3] |=> socket_event_flags[3])
    else $error("expiry flag missing");

  chk_data_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    peer_ev.data && mask_ff[2] |=> socket_event_flags[2])
    else $error("data arrival flag missing");

  chk_fin_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    (peer_ev.fin || peer_ev.finack) && mask_ff[1] |=> socket_event_flags[1])
    else $error("peer finish flag missing");

  chk_link_up_entry: assert property (@(posedge clk) disable iff (!rstn)
    $rose(socket_state == sock_pkg::SC_SESSION_UP) && mask_ff[0]
    |-> socket_event_flags[0])
    else $error("link-up flag not set on session entry");

  chk_state_has_cause: assert property (@(posedge clk) disable iff (!rstn)
    $changed(socket_state) |-> $past(cmd_wr || peer_ev != '0 || linger_done))
    else $error("state moved without a cause");

  chk_close_releases: assert property (@(posedge clk) disable iff (!rstn)
    cmd_wr && cmd == sock_pkg::CMD_CLOSE |=> socket_state == sock_pkg::SC_RELEASED)
    else $error("close did not release");

  chk_open_tcp_state: assert property (@(posedge clk) disable iff (!rstn)
    st_ff == ST_RELEASED && cmd_wr && cmd == sock_pkg::CMD_OPEN &&
    proto_ff[3:0] == sock_pkg::PROTO_TCP |=> socket_state == sock_pkg::SC_TCP_OPENED)
    else $error("TCP open did not reach opened state");

  chk_reset_releases: assert property (@(posedge clk) disable iff (!rstn)
    peer_ev.rst && in_tcp_link(st_ff) |=> socket_state == sock_pkg::SC_RELEASED)
    else $error("peer reset did not release");

  chk_connect_sequence: assert property (@(posedge clk) disable iff (!rstn)
    st_ff == ST_TCP_OPENED && cmd_wr && cmd == sock_pkg::CMD_CONNECT
    |=> socket_state == sock_pkg::SC_REQ_SENT && eng_req.send_syn)
    else $error("connect did not show request sent");

  chk_raw_socket_zero: assert property (@(posedge clk) disable iff (!rstn)
    socket_state == sock_pkg::SC_RAW_FRAME |-> SOCKET_INDEX == 0)
    else $error("raw frame state on a non-zero socket");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
    socket_event_flags[7:5] == 3'h0)
    else $error("reserved flag bits not zero");

  cov_server_session: cover property (@(posedge clk) disable iff (!rstn)
    socket_state == sock_pkg::SC_AWAITING ##[1:20] socket_state == sock_pkg::SC_SESSION_UP);
  cov_half_close: cover property (@(posedge clk) disable iff (!rstn)
    socket_state == sock_pkg::SC_HALF_CLOSED ##[1:20] socket_state == sock_pkg::SC_FINAL_WAIT);
  cov_linger_done: cover property (@(posedge clk) disable iff (!rstn)
    socket_state == sock_pkg::SC_LINGER ##1 socket_state == sock_pkg::SC_RELEASED);
  cov_datagram: cover property (@(posedge clk) disable iff (!rstn)
    socket_state == sock_pkg::SC_DATAGRAM && eng_req.send_mac);

endmodule // sock_state_ctrl

/* File: sim/peer_model.sv */
`timescale 1ns/10ps
module peer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Device side
  input wire sock_pkg::eng_req_t eng_req,
  output sock_pkg::peer_ev_t peer_ev,
  // Bench control
  input wire logic respond,
  input wire logic [3:0] lag,
  input wire sock_pkg::peer_ev_t tb_ev
);
  // ==========================================================
  // Delayed replies
  // Lag must be at least one, a zero lag never answers
  logic [3:0] syn_cnt;
  logic [3:0] fin_cnt;
  sock_pkg::peer_ev_t auto_ev;

  assign peer_ev = sock_pkg::peer_ev_t'(tb_ev | auto_ev);

  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      syn_cnt <= 4'h0;
      fin_cnt <= 4'h0;
      auto_ev <= '0;
    end else begin
      auto_ev <= '0;
      if (eng_req.send_syn && respond) begin
        syn_cnt <= lag;
      end else if (syn_cnt != 4'h0) begin
        syn_cnt <= syn_cnt - 4'h1;
        auto_ev.synack <= (syn_cnt == 4'h1);
      end
      if (eng_req.send_fin && respond) begin
        fin_cnt <= lag;
      end else if (fin_cnt != 4'h0) begin
        fin_cnt <= fin_cnt - 4'h1;
        auto_ev.finack <= (fin_cnt == 4'h1);
      end
    end
  end
endmodule // peer_model

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t mismatch", $time); end end
module tb_top;
  // ==========================================================
  // Signals
  logic clk;
  logic rstn;
  sock_pkg::reg_req_t reg_req;
  logic [7:0] reg_rdata;
  sock_pkg::peer_ev_t tb_ev;
  sock_pkg::peer_ev_t peer_ev;
  sock_pkg::eng_req_t eng_req;
  logic [7:0] st;
  logic [7:0] fl;
  logic respond;
  logic [3:0] lag;
  int failures;
  int total_checks;
  // Engine request pulses seen, one count per pulse
  int n_mac = 0;
  int n_data = 0;
  int n_keep = 0;
  int n_ack = 0;
  int n_abort = 0;
  localparam int unsigned LNG = 4;
  // Bit positions inside the peer event carrier
  localparam int P_SYN = 9, P_REPLY = 7, P_FIN = 6, P_FINACK = 5, P_RST = 4;
  localparam int P_DATA = 3, P_SEND = 2, P_ARP = 1, P_RTO = 0;

  sock_state_ctrl #(.SOCKET_INDEX(0), .LINGER(LNG)) dut_u (.clk(clk), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .peer_ev(peer_ev), .eng_req(eng_req), .socket_state(st), .socket_event_flags(fl));
  peer_model peer_u (.clk(clk), .rstn(rstn), .eng_req(eng_req), .peer_ev(peer_ev), .respond(respond),
    .lag(lag), .tb_ev(tb_ev));

  always @(posedge clk) begin
    n_mac <= n_mac + int'(eng_req.send_mac);
    n_data <= n_data + int'(eng_req.send_data);
    n_keep <= n_keep + int'(eng_req.send_keep);
    n_ack <= n_ack + int'(eng_req.send_synack);
    n_abort <= n_abort + int'(eng_req.abort);
  end

  // ==========================================================
  // Access tasks, entered at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(negedge clk);
    reg_req.wr = 1'b0;
    // Idle cycle, so back-to-back calls never retoggle a strobe at once
    @(negedge clk);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(negedge clk);
    reg_req.rd = 1'b0;
    `CHK(reg_rdata, e)
    @(negedge clk);
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(sock_pkg::OFS_CMD, c);
  endtask

  task automatic open(input logic [3:0] p);
    wr(sock_pkg::OFS_PROTO, {4'h0, p});
    cmd(sock_pkg::CMD_OPEN);
  endtask

  task automatic pulse(input int p);
    tb_ev = sock_pkg::peer_ev_t'(10'h1 << p);
    @(negedge clk);
    tb_ev = '0;
    @(negedge clk);
  endtask

  // Bounded wait for a partner reply
  task automatic wait_state(input logic [7:0] e);
    for (int i = 0; i < 20 && st !== e; i++) begin
      @(negedge clk);
    end
    `CHK(st, e)
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #20000;
    failures++;
    give_verdict;
  end

  // ==========================================================
  // Tests
  initial begin
    rstn = 1'b0;
    reg_req = '0;
    tb_ev = '0;
    respond = 1'b1;
    lag = 4'h1;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk_rd(sock_pkg::OFS_STATE, sock_pkg::STATE_RST);
    chk_rd(sock_pkg::OFS_MASK, sock_pkg::MASK_RST);
    chk_rd(8'h7f, 8'h00);
    wr(sock_pkg::OFS_STATE, 8'h17);
    cmd(sock_pkg::CMD_LISTEN);
    `CHK(st, sock_pkg::SC_RELEASED)
    // Masked events must leave the flags alone
    wr(sock_pkg::OFS_MASK, 8'h00);
    pulse(P_DATA);
    pulse(P_FIN);
    `CHK(fl, 8'h00)
    `CHK(st, sock_pkg::SC_RELEASED)
    wr(sock_pkg::OFS_MASK, 8'hff);
    open(sock_pkg::PROTO_UDP);
    `CHK(st, sock_pkg::SC_DATAGRAM)
    cmd(sock_pkg::CMD_SEND_MAC);
    cmd(sock_pkg::CMD_SEND);
    `CHK(n_mac, 1)
    `CHK(n_data, 1)
    pulse(P_SEND);
    `CHK(fl, 8'h10)
    cmd(sock_pkg::CMD_CLOSE);
    `CHK(st, sock_pkg::SC_RELEASED)
    wr(sock_pkg::OFS_FLAGS, 8'hff);
    `CHK(fl, 8'h00)
    open(sock_pkg::PROTO_RAW);
    `CHK(st, sock_pkg::SC_RAW_FRAME)
    cmd(sock_pkg::CMD_SEND_MAC);
    `CHK(n_mac, 1)
    cmd(sock_pkg::CMD_CLOSE);
    // Client side, slow reply
    open(sock_pkg::PROTO_TCP);
    `CHK(st, sock_pkg::SC_TCP_OPENED)
    lag = 4'h5;
    cmd(sock_pkg::CMD_CONNECT);
    `CHK(st, sock_pkg::SC_REQ_SENT)
    wait_state(sock_pkg::SC_SESSION_UP);
    `CHK(fl, 8'h01)
    cmd(sock_pkg::CMD_SEND_KEEP);
    cmd(sock_pkg::CMD_SEND);
    `CHK(n_keep, 1)
    `CHK(n_data, 2)
    pulse(P_DATA);
    pulse(P_SEND);
    `CHK(fl, 8'h15)
    wr(sock_pkg::OFS_FLAGS, 8'he4);
    chk_rd(sock_pkg::OFS_FLAGS, 8'h11);
    wr(sock_pkg::OFS_FLAGS, 8'h11);
    pulse(P_FIN);
    `CHK(st, sock_pkg::SC_HALF_CLOSED)
    `CHK(fl, 8'h02)
    pulse(P_DATA);
    `CHK(st, sock_pkg::SC_HALF_CLOSED)
    lag = 4'h1;
    cmd(sock_pkg::CMD_PEER_FIN_FLAG);
    `CHK(st, sock_pkg::SC_FINAL_WAIT)
    wait_state(sock_pkg::SC_RELEASED);
    `CHK(fl[0], 1'b0)
    wr(sock_pkg::OFS_FLAGS, 8'hff);
    // Server side, then active close through linger
    open(sock_pkg::PROTO_TCP);
    cmd(sock_pkg::CMD_LISTEN);
    `CHK(st, sock_pkg::SC_AWAITING)
    pulse(P_SYN);
    `CHK(st, sock_pkg::SC_REQ_RCVD)
    pulse(P_REPLY);
    `CHK(st, sock_pkg::SC_SESSION_UP)
    `CHK(fl, 8'h01)
    respond = 1'b0;
    cmd(sock_pkg::CMD_PEER_FIN_FLAG);
    `CHK(st, sock_pkg::SC_FINISH_PEND)
    pulse(P_FIN);
    `CHK(st, sock_pkg::SC_SHUTTING)
    pulse(P_FINACK);
    `CHK(st, sock_pkg::SC_LINGER)
    repeat (LNG - 2) @(negedge clk);
    `CHK(st, sock_pkg::SC_LINGER)
    repeat (2) @(negedge clk);
    `CHK(st, sock_pkg::SC_RELEASED)
    wr(sock_pkg::OFS_FLAGS, 8'hff);
    // Silent peer: expiries
    open(sock_pkg::PROTO_TCP);
    cmd(sock_pkg::CMD_CONNECT);
    repeat (8) @(negedge clk);
    `CHK(st, sock_pkg::SC_REQ_SENT)
    pulse(P_RTO);
    `CHK(st, sock_pkg::SC_RELEASED)
    `CHK(fl, 8'h08)
    wr(sock_pkg::OFS_FLAGS, 8'h08);
    pulse(P_ARP);
    `CHK(fl, 8'h08)
    open(sock_pkg::PROTO_TCP);
    cmd(sock_pkg::CMD_LISTEN);
    pulse(P_RTO);
    `CHK(st, sock_pkg::SC_RELEASED)
    open(sock_pkg::PROTO_TCP);
    cmd(sock_pkg::CMD_LISTEN);
    pulse(P_SYN);
    pulse(P_RST);
    `CHK(st, sock_pkg::SC_RELEASED)
    `CHK(n_ack, 2)
    `CHK(n_abort, 7)
    give_verdict;
  end
endmodule // tb_top
